// ===== rtl/sdac_map.vh
/*
 * sdac_map.vh: register offsets, field positions, reset values and timing
 * constants for the delta-sigma converter control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SDAC_MAP_VH
`define SDAC_MAP_VH

// register byte addresses (index times four)
`define SDAC_IDX_CTRL_A 8'hDC
`define SDAC_IDX_CTRL_B 8'hDD
`define SDAC_IDX_TRIM 8'hE6
`define SDAC_IDX_DIV 8'hF6
`define SDAC_ADDR_CTRL_A 12'h370
`define SDAC_ADDR_CTRL_B 12'h374
`define SDAC_ADDR_TRIM 12'h398
`define SDAC_ADDR_DIV 12'h3D8
`define SDAC_ADDR_MUX 12'h400
`define SDAC_ADDR_DEC 12'h404
`define SDAC_ADDR_CURRENT_OUTPUT_DAC 12'h408
`define SDAC_ADDR_STAT 12'h40C
`define SDAC_ADDR_SYS 12'h410

// converter_control_a fields
`define SDAC_A_GAIN_LSB 0
`define SDAC_A_BUF_BIT 3
`define SDAC_A_REF_LSB 4
`define SDAC_A_OSD_BIT 6
`define SDAC_A_RESET 8'h00
// converter_control_b fields
`define SDAC_B_CAL_LSB 0
`define SDAC_B_FILT_LSB 4
`define SDAC_B_RESET 8'h00
// mux register fields
`define SDAC_MUX_NEG_LSB 0
`define SDAC_MUX_POS_LSB 4
`define SDAC_MUX_RESET 8'h01
`define SDAC_TEMP_SEL 4'hF
// reference codes; 00 is internal 2.5 V so reset gives it
`define SDAC_REF_INT_2V5 2'h0
`define SDAC_REF_INT_1V25 2'h1
`define SDAC_REF_EXT 2'h2
// filter codes
`define SDAC_FILT_AUTO 2'h0
`define SDAC_FILT_FAST 2'h1
`define SDAC_FILT_SINC2 2'h2
`define SDAC_FILT_SINC3 2'h3
// calibration codes
`define SDAC_CAL_NONE 3'h0
`define SDAC_CAL_SELF_BOTH 3'h1
`define SDAC_CAL_SELF_OFS 3'h2
`define SDAC_CAL_SELF_GAIN 3'h3
`define SDAC_CAL_SYS_OFS 3'h4
`define SDAC_CAL_SYS_GAIN 3'h5
`define SDAC_CAL_SHORT 8'h07
`define SDAC_CAL_LONG 8'h0E
// status bits
`define SDAC_ST_IRQ_BIT 0
`define SDAC_ST_CAL_BIT 1
`define SDAC_ST_DISC_BIT 2
`define SDAC_ST_MODE_BIT 3
// system register bits
`define SDAC_SYS_SWRST_BIT 0
// clocks per modulator period
`define SDAC_MOD_DIV 64
`define SDAC_DEC_RESET 16'h00FF
`define SDAC_DIV_RESET 8'h00

`endif

// ===== rtl/sdac_clkgen.v
/*
 * sdac_clkgen.v: analog clock divider and modulator tick generator.
 * Assumes pclk as system clock; divider value may change any time and
 * takes effect at once, ending or stretching the current analog period.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_map.vh"

module sdac_clkgen (
    input wire pclk,
    input wire rst_n,
    input wire [7:0] divider,
    output reg aclk_tick,
    output reg mod_tick
);
    reg [7:0] div_cnt;
    reg [5:0] mod_cnt;

    // analog clock = pclk/(divider+1); modulator = analog/64
    always @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= 8'h00;
            mod_cnt <= 6'h00;
            aclk_tick <= 1'b0;
            mod_tick <= 1'b0;
        end
        else
        begin
            aclk_tick <= 1'b0;
            mod_tick <= 1'b0;
            if (div_cnt >= divider)
            begin
                div_cnt <= 8'h00;
                aclk_tick <= 1'b1;
                mod_cnt <= mod_cnt + 6'h01;
                if (mod_cnt == 6'h3F)
                begin
                    mod_tick <= 1'b1;
                end
            end
            else
            begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end
endmodule // sdac_clkgen

`default_nettype wire

// ===== rtl/sdac_rstctl.v
/*
 * sdac_rstctl.v: reset source combiner and program-mode strap capture.
 * Assumes presetn is power-on reset; pin inputs are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none

module sdac_rstctl (
    input wire pclk,
    input wire presetn,
    input wire ext_reset_pin,
    input wire brownout_reset,
    input wire soft_reset_req,
    input wire program_mode_strap,
    output wire rst_n,
    output reg user_application_mode,
    output wire halted
);
    reg [2:0] pin_sync;
    reg [2:0] bor_sync;
    reg [2:0] strap_sync;
    reg pin_level;
    reg bor_level;
    reg strap_level;
    reg [1:0] rel;
    reg soft_hold;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync <= 3'h0;
            bor_sync <= 3'h0;
            strap_sync <= 3'h7;
            pin_level <= 1'b0;
            bor_level <= 1'b0;
            strap_level <= 1'b1;
        end
        else
        begin
            pin_sync <= {pin_sync[1:0], ext_reset_pin};
            bor_sync <= {bor_sync[1:0], brownout_reset};
            strap_sync <= {strap_sync[1:0], program_mode_strap};
            if (pin_sync[1] == pin_sync[2])
                pin_level <= pin_sync[2];
            if (bor_sync[1] == bor_sync[2])
                bor_level <= bor_sync[2];
            if (strap_sync[1] == strap_sync[2])
                strap_level <= strap_sync[2];
        end
    end

    // pin high halts; release low starts the reset sequence
    assign halted = pin_level;

    // power-on, pin, brownout or software request
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rel <= 2'h0;
            soft_hold <= 1'b0;
        end
        else
        begin
            soft_hold <= soft_reset_req;
            if (pin_level || bor_level || soft_hold)
                rel <= 2'h0;
            else if (rel != 2'h3)
                rel <= rel + 2'h1;
        end
    end
    assign rst_n = (rel == 2'h3) && !pin_level;

    // strap sampled while internal reset holds
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            user_application_mode <= 1'b1;
        else if (!rst_n)
            user_application_mode <= strap_level;
    end
endmodule // sdac_rstctl

`default_nettype wire

// ===== rtl/sdac_ctrl.v
/*
 * sdac_ctrl.v: digital control of a delta-sigma converter front end:
 * mux, buffer, open-sensor detect, gain, offset trim, reference, current
 * DAC, clock divider, decimation, calibration and filter sequencing.
 * Assumes an APB master on pclk; analog blocks take the static outputs.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sdac_map.vh"

module sdac_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ext_reset_pin,
    input wire brownout_reset,
    input wire program_mode_strap,
    output wire user_application_mode,
    output wire device_halted,
    output reg [3:0] mux_pos,
    output reg [3:0] mux_neg,
    output reg temp_sensor_en,
    output reg open_sensor_detect_enable,
    output reg buffer_en,
    output reg [2:0] gain_stage,
    output reg [7:0] analog_offset_trim,
    output reg [1:0] ref_select,
    output reg [7:0] current_output_dac,
    output reg modulator_clk_tick,
    output reg data_ready,
    output reg [1:0] filter_active,
    output reg cal_active,
    output reg [2:0] cal_mode
);
    reg [7:0] converter_control_a;
    reg [7:0] converter_control_b;
    reg [7:0] analog_clock_divider;
    reg [7:0] mux_sel;
    reg [15:0] decimation;
    reg [7:0] current_output_dac_code;
    reg soft_reset_req;
    reg conv_irq;
    reg discard;
    reg [15:0] dec_cnt;
    reg [7:0] cal_left;
    reg [1:0] auto_step;
    reg [31:0] rdata;
    reg next_conv_irq;
    wire rst_n;
    wire aclk_tick;
    wire mod_tick;
    wire wr;
    wire rd_stat;
    wire chg;
    wire conv_done;
    wire [2:0] cal_req;
    wire [7:0] cal_len;

    sdac_rstctl u_rst (
        .pclk(pclk),
        .presetn(presetn),
        .ext_reset_pin(ext_reset_pin),
        .brownout_reset(brownout_reset),
        .soft_reset_req(soft_reset_req),
        .program_mode_strap(program_mode_strap),
        .rst_n(rst_n),
        .user_application_mode(user_application_mode),
        .halted(device_halted)
    );

    sdac_clkgen u_clk (
        .pclk(pclk),
        .rst_n(rst_n),
        .divider(analog_clock_divider),
        .aclk_tick(aclk_tick),
        .mod_tick(mod_tick)
    );

    // zero wait states; write lands at access edge
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd_stat = psel && penable && !pwrite &&
        (paddr == `SDAC_ADDR_STAT);
    assign prdata = rdata;
    // unmapped or unaligned addresses answer with an error
    assign pslverr = psel && penable && (paddr[1:0] != 2'h0 ||
        !(paddr == `SDAC_ADDR_CTRL_A || paddr == `SDAC_ADDR_CTRL_B ||
        paddr == `SDAC_ADDR_TRIM || paddr == `SDAC_ADDR_DIV ||
        paddr == `SDAC_ADDR_MUX || paddr == `SDAC_ADDR_DEC ||
        paddr == `SDAC_ADDR_CURRENT_OUTPUT_DAC || paddr == `SDAC_ADDR_STAT ||
        paddr == `SDAC_ADDR_SYS));

    always @*
    begin
        case (paddr)
            `SDAC_ADDR_CTRL_A: rdata = {24'h000000, converter_control_a};
            `SDAC_ADDR_CTRL_B: rdata = {24'h000000, converter_control_b};
            `SDAC_ADDR_TRIM: rdata = {24'h000000, analog_offset_trim};
            `SDAC_ADDR_DIV: rdata = {24'h000000, analog_clock_divider};
            `SDAC_ADDR_MUX: rdata = {24'h000000, mux_sel};
            `SDAC_ADDR_DEC: rdata = {16'h0000, decimation};
            `SDAC_ADDR_CURRENT_OUTPUT_DAC: rdata = {24'h000000, current_output_dac_code};
            `SDAC_ADDR_STAT: rdata = {28'h0000000, (filter_active ==
                `SDAC_FILT_FAST), discard, cal_active, conv_irq};
            default: rdata = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            converter_control_a <= `SDAC_A_RESET;
            analog_offset_trim <= 8'h00;
            analog_clock_divider <= `SDAC_DIV_RESET;
            mux_sel <= `SDAC_MUX_RESET;
            decimation <= `SDAC_DEC_RESET;
            current_output_dac_code <= 8'h00;
            soft_reset_req <= 1'b0;
        end
        else
        begin
            soft_reset_req <= 1'b0;
            if (wr)
            begin
                case (paddr)
                    `SDAC_ADDR_CTRL_A: converter_control_a <= pwdata[7:0];
                    `SDAC_ADDR_TRIM: analog_offset_trim <= pwdata[7:0];
                    `SDAC_ADDR_DIV: analog_clock_divider <= pwdata[7:0];
                    `SDAC_ADDR_MUX: mux_sel <= pwdata[7:0];
                    `SDAC_ADDR_DEC:
                        decimation <= (pwdata[15:0] == 16'h0000) ?
                            16'h0001 : pwdata[15:0];
                    `SDAC_ADDR_CURRENT_OUTPUT_DAC: current_output_dac_code <= pwdata[7:0];
                    `SDAC_ADDR_SYS:
                        soft_reset_req <= pwdata[`SDAC_SYS_SWRST_BIT];
                    default: soft_reset_req <= 1'b0;
                endcase
            end
        end
    end

    // analog-facing decode of the control registers
    always @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mux_pos <= 4'h0;
            mux_neg <= 4'h1;
            temp_sensor_en <= 1'b0;
            open_sensor_detect_enable <= 1'b0;
            buffer_en <= 1'b0;
            gain_stage <= 3'h0;
            ref_select <= `SDAC_REF_INT_2V5;
            current_output_dac <= 8'h00;
            modulator_clk_tick <= 1'b0;
        end
        else
        begin
            modulator_clk_tick <= mod_tick;
            // temperature diodes take over, every channel open
            temp_sensor_en <= (mux_sel[7:4] == `SDAC_TEMP_SEL);
            // any pos/neg pair; zero pos with any neg; swap is just
            // writing the pair reversed, giving polarity reversal
            mux_pos <= mux_sel[7:4];
            mux_neg <= mux_sel[3:0];
            open_sensor_detect_enable <=
                converter_control_a[`SDAC_A_OSD_BIT];
            buffer_en <= converter_control_a[`SDAC_A_BUF_BIT];
            gain_stage <= converter_control_a[2:0];
            // code 3 is unused; falls back to internal 2.5 V
            ref_select <= (converter_control_a[5:4] == 2'h3) ?
                `SDAC_REF_INT_2V5 : converter_control_a[5:4];
            current_output_dac <= current_output_dac_code;
        end
    end

    // a channel or gain change restarts automatic filter sequence
    assign chg = wr && ((paddr == `SDAC_ADDR_MUX && pwdata[7:0] != mux_sel)
        || (paddr == `SDAC_ADDR_CTRL_A &&
        pwdata[2:0] != converter_control_a[2:0]));
    assign conv_done = mod_tick && (dec_cnt + 16'h0001 >= decimation);
    assign cal_req = pwdata[2:0];
    assign cal_len = (cal_req == `SDAC_CAL_SELF_BOTH) ?
        `SDAC_CAL_LONG : `SDAC_CAL_SHORT;

    // set beats a status-read clear
    always @*
    begin
        next_conv_irq = conv_irq;
        if (rd_stat)
            next_conv_irq = 1'b0;
        if (conv_done && (!cal_active || cal_left == 8'h01))
            next_conv_irq = 1'b1;
    end

    always @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            converter_control_b <= `SDAC_B_RESET;
            conv_irq <= 1'b0;
            discard <= 1'b0;
            dec_cnt <= 16'h0000;
            cal_left <= 8'h00;
            cal_active <= 1'b0;
            cal_mode <= `SDAC_CAL_NONE;
            auto_step <= 2'h3;
            filter_active <= `SDAC_FILT_SINC3;
            data_ready <= 1'b0;
        end
        else
        begin
            conv_irq <= next_conv_irq;
            data_ready <= conv_done && !cal_active &&
                !(wr && paddr == `SDAC_ADDR_CTRL_B);
            if (mod_tick)
                dec_cnt <= conv_done ? 16'h0000 : dec_cnt + 16'h0001;
            if (wr && paddr == `SDAC_ADDR_CTRL_B)
            begin
                converter_control_b <= {pwdata[7:4], 1'b0, 3'h0};
                if (cal_req != `SDAC_CAL_NONE && cal_req <= `SDAC_CAL_SYS_GAIN)
                begin
                    // system gain relies on full-scale input
                    cal_active <= 1'b1;
                    cal_mode <= cal_req;
                    cal_left <= cal_len;
                    dec_cnt <= 16'h0000;
                end
            end
            else if (conv_done && cal_active)
            begin
                cal_left <= cal_left - 8'h01;
                if (cal_left == 8'h01)
                begin
                    cal_active <= 1'b0;
                    cal_mode <= `SDAC_CAL_NONE;
                end
            end
            if (chg)
            begin
                auto_step <= 2'h0;
                dec_cnt <= 16'h0000;
            end
            else if (conv_done && auto_step != 2'h3)
                auto_step <= auto_step + 2'h1;
            if (conv_done)
                discard <= (auto_step == 2'h0) && !chg;
            case (converter_control_b[5:4])
                `SDAC_FILT_AUTO:
                    filter_active <= (auto_step <= 2'h1) ? `SDAC_FILT_FAST :
                        (auto_step == 2'h2) ? `SDAC_FILT_SINC2 :
                        `SDAC_FILT_SINC3;
                `SDAC_FILT_FAST: filter_active <= `SDAC_FILT_FAST;
                `SDAC_FILT_SINC2: filter_active <= `SDAC_FILT_SINC2;
                default: filter_active <= `SDAC_FILT_SINC3;
            endcase
        end
    end
endmodule // sdac_ctrl

`default_nettype wire

// ===== verif/sdac_ctrl_checker.sv
/* sdac_ctrl_checker.sv: port-level checks for sdac_ctrl.
   Assumes binding into sdac_ctrl; pclk and presetn as clock and reset. */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_map.vh"
module sdac_ctrl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic device_halted,
    input wire logic [3:0] mux_pos,
    input wire logic [3:0] mux_neg,
    input wire logic temp_sensor_en,
    input wire logic open_sensor_detect_enable,
    input wire logic buffer_en,
    input wire logic [2:0] gain_stage,
    input wire logic [7:0] analog_offset_trim,
    input wire logic [1:0] ref_select,
    input wire logic [7:0] current_output_dac,
    input wire logic modulator_clk_tick,
    input wire logic data_ready,
    input wire logic [1:0] filter_active,
    input wire logic cal_active,
    input wire logic [2:0] cal_mode
);
    logic wr_ok;
    logic [1:0] fmode;
    logic [2:0] ccode;
    logic [15:0] gap;
    logic seen;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_ok = psel && penable && pwrite && pready && !pslverr
        && !device_halted;
    // shadow of last filter and calibration codes written
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fmode <= 2'h0;
            ccode <= 3'h0;
            gap <= 16'h0000;
            seen <= 1'b0;
        end
        else
        begin
            if (wr_ok && paddr == `SDAC_ADDR_CTRL_B)
            begin
                fmode <= pwdata[5:4];
                ccode <= pwdata[2:0];
            end
            seen <= seen | modulator_clk_tick;
            gap <= modulator_clk_tick ? 16'h0000 :
                (gap == 16'hFFFF ? gap : gap + 16'h0001);
        end
    end
    a_ctrl_a_fields: assert property (wr_ok && paddr == `SDAC_ADDR_CTRL_A |=> ##1
        gain_stage == $past(pwdata[2:0],2) && buffer_en == $past(pwdata[3],2)
        && open_sensor_detect_enable == $past(pwdata[6],2)) else $error("ctrl a fields");
    a_ref_decode: assert property (wr_ok && paddr == `SDAC_ADDR_CTRL_A |=> ##1
        ref_select == ($past(pwdata[5:4],2) == 2'h3 ? 2'h0 : $past(pwdata[5:4],2)))
        else $error("reference select");
    a_mux_fields: assert property (wr_ok && paddr == `SDAC_ADDR_MUX |=> ##1
        mux_pos == $past(pwdata[7:4],2) && mux_neg == $past(pwdata[3:0],2))
        else $error("mux fields");
    a_temp_select: assert property (temp_sensor_en == (mux_pos == 4'hF))
        else $error("temperature select");
    a_trim_write: assert property (wr_ok && paddr == `SDAC_ADDR_TRIM |=>
        analog_offset_trim == $past(pwdata[7:0])) else $error("trim");
    a_current_output_dac_write: assert property (wr_ok && paddr == `SDAC_ADDR_CURRENT_OUTPUT_DAC |=> ##1
        current_output_dac == $past(pwdata[7:0],2)) else $error("current_output_dac");
    a_mod_gap: assert property (modulator_clk_tick && seen |-> gap >= 16'd63)
        else $error("modulator tick too early");
    a_filter_fixed: assert property (wr_ok && paddr == `SDAC_ADDR_CTRL_B
        && pwdata[5:4] != 2'h0 |=> ##[0:2] filter_active == fmode)
        else $error("fixed filter");
    a_auto_restart: assert property (wr_ok && paddr == `SDAC_ADDR_MUX
        && fmode == 2'h0 |=> ##[0:2] filter_active == 2'h1) else $error("auto filter");
    a_cal_quiet: assert property (cal_active |-> !data_ready)
        else $error("data during calibration");
    a_cal_start: assert property (wr_ok && paddr == `SDAC_ADDR_CTRL_B && !cal_active
        && pwdata[2:0] inside {[3'h1:3'h5]} |=> ##[0:2] cal_active && cal_mode == ccode)
        else $error("calibration start");
    a_halt_quiet: assert property (device_halted |-> !cal_active && !data_ready)
        else $error("activity while halted");
endmodule // sdac_ctrl_checker
bind sdac_ctrl sdac_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .device_halted(device_halted), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .temp_sensor_en(temp_sensor_en), .buffer_en(buffer_en),
    .open_sensor_detect_enable(open_sensor_detect_enable),
    .gain_stage(gain_stage), .analog_offset_trim(analog_offset_trim),
    .ref_select(ref_select), .current_output_dac(current_output_dac),
    .modulator_clk_tick(modulator_clk_tick), .data_ready(data_ready),
    .filter_active(filter_active), .cal_active(cal_active),
    .cal_mode(cal_mode));
`default_nettype wire

// ===== verif/sdac_sensor_model.sv
/* sdac_sensor_model.sv: sensor side seen through the input mux.
   Assumes static mux and calibration outputs of sdac_ctrl. */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_map.vh"
module sdac_sensor_model (
    input wire logic [3:0] mux_pos,
    input wire logic [3:0] mux_neg,
    input wire logic cal_active,
    input wire logic [2:0] cal_mode,
    output logic full_scale_applied,
    output logic [7:0] sensed_code
);
    // system gain calibration is only valid with full scale across the pair
    assign full_scale_applied = cal_active
        && cal_mode == `SDAC_CAL_SYS_GAIN;
    assign sensed_code = full_scale_applied ? 8'h7F : {mux_pos, mux_neg};
endmodule // sdac_sensor_model
`default_nettype wire

// ===== verif/testbench.sv
/* testbench.sv: self-checking bench for sdac_ctrl over APB.
   Assumes the design's register map header and a 25 MHz pclk. */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_map.vh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic ext_reset_pin, brownout_reset, program_mode_strap;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdv;
    wire [31:0] prdata;
    wire pready, pslverr, user_application_mode, device_halted;
    wire temp_sensor_en, open_sensor_detect_enable, buffer_en;
    wire modulator_clk_tick, data_ready, cal_active, full_scale_applied;
    wire [3:0] mux_pos, mux_neg;
    wire [2:0] gain_stage, cal_mode;
    wire [7:0] analog_offset_trim, current_output_dac, sensed_code;
    wire [1:0] ref_select, filter_active;
    int n_fail, samples_checked, cycles, i, n, k;
    sdac_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_pin(ext_reset_pin), .brownout_reset(brownout_reset),
        .program_mode_strap(program_mode_strap),
        .user_application_mode(user_application_mode),
        .device_halted(device_halted), .mux_pos(mux_pos), .mux_neg(mux_neg),
        .temp_sensor_en(temp_sensor_en), .buffer_en(buffer_en),
        .open_sensor_detect_enable(open_sensor_detect_enable),
        .gain_stage(gain_stage), .analog_offset_trim(analog_offset_trim),
        .ref_select(ref_select), .current_output_dac(current_output_dac),
        .modulator_clk_tick(modulator_clk_tick), .data_ready(data_ready),
        .filter_active(filter_active), .cal_active(cal_active),
        .cal_mode(cal_mode));
    sdac_sensor_model u_sensor (.mux_pos(mux_pos), .mux_neg(mux_neg),
        .cal_active(cal_active), .cal_mode(cal_mode),
        .full_scale_applied(full_scale_applied), .sensed_code(sensed_code));
    task wrap_up;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input [11:0] a, input w, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // decoded outputs lag the write by two edges
    task wr(input [11:0] a, input [31:0] d);
        apb(a, 1'b1, d);
        repeat (2) @(posedge pclk);
    endtask
    task rd(input [11:0] a);
        apb(a, 1'b0, 32'h0);
    endtask
    task wait_sig(input s);
        @(posedge pclk);
        while ((s ? data_ready : modulator_clk_tick) !== 1'b1) @(posedge pclk);
    endtask
    task gap(input s);
        wait_sig(s);
        n = 1;
        @(posedge pclk);
        while ((s ? data_ready : modulator_clk_tick) !== 1'b1)
        begin
            @(posedge pclk);
            n++;
        end
    endtask
    task t_regs;
        chk(ref_select, 0);
        rd(`SDAC_ADDR_CTRL_A);
        chk(rdv, `SDAC_A_RESET);
        rd(`SDAC_ADDR_MUX);
        chk(rdv, `SDAC_MUX_RESET);
        rd(`SDAC_ADDR_DEC);
        chk(rdv, `SDAC_DEC_RESET);
        rd(12'h500);
        chk({rdv, err}, 33'h1);
        $display("test regs done");
    endtask
    task t_ctrl_a;
        for (i = 0; i < 8; i++)
        begin
            wr(`SDAC_ADDR_CTRL_A, {i[1], i[1:0], i[0], i[2:0]});
            chk(gain_stage, i);
            chk(ref_select, i[1:0] == 2'h3 ? 0 : i[1:0]);
            chk({open_sensor_detect_enable, buffer_en}, {i[1], i[0]});
        end
        $display("test ctrl_a done");
    endtask
    task t_mux_dac;
        for (i = 1; i < 6; i++)
        begin
            wr(`SDAC_ADDR_MUX, {i[3:0], 4'h0});
            chk({mux_pos, mux_neg, temp_sensor_en}, {i[3:0], 5'h0});
            wr(`SDAC_ADDR_MUX, {4'h0, i[3:0]});
            chk({mux_pos, mux_neg}, {4'h0, i[3:0]});
        end
        wr(`SDAC_ADDR_MUX, 8'hF0);
        chk(temp_sensor_en, 1);
        for (i = 0; i < 256; i += 85)
        begin
            wr(`SDAC_ADDR_TRIM, i ^ 8'h80);
            chk(analog_offset_trim, i ^ 8'h80);
            wr(`SDAC_ADDR_CURRENT_OUTPUT_DAC, i);
            chk(current_output_dac, i);
        end
        $display("test mux and dacs done");
    endtask
    task t_filter;
        wr(`SDAC_ADDR_DEC, 1);
        for (i = 1; i < 4; i++)
        begin
            wr(`SDAC_ADDR_CTRL_B, {i[1:0], 4'h0});
            chk(filter_active, i);
        end
        wr(`SDAC_ADDR_CTRL_B, 8'h00);
        wr(`SDAC_ADDR_MUX, 8'h02);
        chk(filter_active, 1);
        for (k = 0; k < 3; k++)
        begin
            wait_sig(1'b1);
            repeat (32) @(posedge pclk);
            chk(filter_active, k == 0 ? 1 : k + 1);
        end
        wr(`SDAC_ADDR_CTRL_A, 8'h02);
        chk(filter_active, 1);
        $display("test filter done");
    endtask
    task t_rates;
        gap(1'b0);
        chk(n, 64);
        wr(`SDAC_ADDR_DIV, 8'h01);
        wr(`SDAC_ADDR_DEC, 8'h02);
        gap(1'b0);
        gap(1'b0);
        chk(n, 128);
        gap(1'b1);
        gap(1'b1);
        chk(n, 256);
        rd(`SDAC_ADDR_STAT);
        chk(rdv[0], 1);
        wr(`SDAC_ADDR_DIV, 8'h00);
        wr(`SDAC_ADDR_DEC, 8'h01);
        $display("test rates done");
    endtask
    task t_cal;
        // recalibrate after the rate and gain changes
        for (i = 1; i < 6; i++)
        begin
            wr(`SDAC_ADDR_CTRL_B, 8'h30 | i);
            while (cal_active !== 1'b1) @(posedge pclk);
            chk({full_scale_applied, cal_mode}, {i == 5, i[2:0]});
            n = 0;
            while (cal_active === 1'b1)
            begin
                @(posedge pclk);
                n++;
            end
            k = (i == 1) ? 14 : 7;
            chk(n >= (k - 1) * 64 && n <= (k + 1) * 64, 1);
            rd(`SDAC_ADDR_STAT);
            chk(rdv[1:0], 2'h1);
        end
        $display("test calibration done");
    endtask
    task t_resets;
        wr(`SDAC_ADDR_TRIM, 8'h5A);
        ext_reset_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(device_halted, 1);
        ext_reset_pin <= 1'b0;
        repeat (12) @(posedge pclk);
        chk(device_halted, 0);
        rd(`SDAC_ADDR_TRIM);
        chk(rdv, 0);
        wr(`SDAC_ADDR_TRIM, 8'h33);
        program_mode_strap <= 1'b0;
        brownout_reset <= 1'b1;
        repeat (8) @(posedge pclk);
        brownout_reset <= 1'b0;
        repeat (12) @(posedge pclk);
        chk(user_application_mode, 0);
        rd(`SDAC_ADDR_TRIM);
        chk(rdv, 0);
        wr(`SDAC_ADDR_TRIM, 8'h44);
        program_mode_strap <= 1'b1;
        wr(`SDAC_ADDR_SYS, 32'h1);
        repeat (12) @(posedge pclk);
        chk(user_application_mode, 1);
        rd(`SDAC_ADDR_TRIM);
        chk(rdv, 0);
        $display("test resets done");
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // hang guard above any test length
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, ext_reset_pin, brownout_reset} = 6'h0;
        program_mode_strap = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_ctrl_a();
        t_mux_dac();
        t_filter();
        t_rates();
        t_cal();
        t_resets();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
